// ===== dv/lpms_cpu_model.sv
// cpu model: wait instruction and clock frequency steps
`timescale 1ns/1ps
`default_nettype none
module lpms_cpu_model (
   // clock
   input wire logic i_clk,
   // cpu requests
   output logic [2:0] o_target,
   output logic o_wait,
   output logic [15:0] o_khz
);
   initial begin
      o_target = 3'h0;
      o_wait = 1'b0;
      o_khz = 16'h0fa0;
   end
   task automatic sleep_on(input logic [2:0] m);
      @(posedge i_clk);
      o_target <= m;
      o_wait <= 1'b1;
      @(posedge i_clk);
      o_wait <= 1'b0;
   endtask
   // ---
   // steps kept within a factor of four, 5 us apart
   // ---
   task automatic set_khz(input logic [15:0] k);
      int f;
      while (o_khz != k) begin
         f = int'(o_khz);
         @(posedge i_clk);
         if (int'(k) >= 4 * f) o_khz <= 16'(4 * f - 1);
         else if (4 * int'(k) <= f) o_khz <= 16'(f / 4 + 1);
         else o_khz <= k;
         repeat (100) @(posedge i_clk);
      end
   endtask
endmodule
`default_nettype wire

// ===== dv/lpms_sva.sv
// checker: port properties of the low power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module lpms_sva
   import lpms_pkg::*;
#(
   parameter int STOP_WAKE_CYC = 2,
   parameter int STBY_WAKE_CYC = 2
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // inputs
   input wire logic i_wait_instr,
   input wire logic [1:0] i_vrange,
   input wire logic [LPMS_KHZ_W-1:0] i_cpu_khz,
   input wire logic i_wdg_en,
   input wire logic [LPMS_EXT_LINES-1:0] i_external_event_line,
   input wire logic [LPMS_WAKE_PINS-1:0] i_standby_wake_pin,
   // outputs
   input wire logic [2:0] o_mode,
   input wire logic o_cpu_clk_en,
   input wire logic o_core_clk_en,
   input wire logic o_slow_osc_en,
   input wire logic o_wdg_clk_en,
   input wire logic o_reg_lp,
   input wire logic o_reg_off,
   input wire logic o_core_pwr_on,
   input wire logic o_flash_wait_state
);
   // ---
   // helpers
   // ---
   localparam int STOP_LIM = STOP_WAKE_CYC + 12;
   localparam int STBY_LIM = STBY_WAKE_CYC + 12;
   int khz;
   logic ws_exp;
   assign khz = int'(i_cpu_khz);
   assign ws_exp = (i_vrange == LPMS_RANGE1) ? khz > LPMS_R1_WS_KHZ :
      (i_vrange == LPMS_RANGE2) ? khz > LPMS_R2_WS_KHZ : khz > LPMS_R3_WS_KHZ;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_settled;
      ($stable(i_cpu_khz) && $stable(i_vrange) && o_mode == 3'h0)[*4];
   endsequence
   sleep_clk_a:
      assert property (o_mode == 3'h1 |-> !o_cpu_clk_en && o_core_clk_en)
      else $error("sleep gating wrong");
   lp_wake_a:
      assert property ($past(o_mode) == 3'h3 && o_mode == 3'h0 |-> !o_reg_lp)
      else $error("regulator left in low power");
   stop_cal_a:
      assert property (o_mode == 3'h4 |-> !o_core_clk_en && o_slow_osc_en
         && o_reg_lp) else $error("stop gating wrong");
   stop_off_a:
      assert property (o_mode == 3'h5 |-> !o_core_clk_en && !o_slow_osc_en)
      else $error("stop clocks not all off");
   stop_wake_a:
      assert property (o_mode inside {3'h4, 3'h5} && $rose(
         i_external_event_line[0]) |-> ##[1:STOP_LIM] o_mode == 3'h0)
      else $error("stop wake too slow");
   stby_off_a:
      assert property ($changed(o_mode) && o_mode[2:1] == 2'h3 |-> o_reg_off
         && !o_core_pwr_on) else $error("standby power not off");
   entry_wait_a:
      assert property ($changed(o_mode) && o_mode inside {3'h1, [3'h3:3'h7]}
         |-> $past(i_wait_instr, 2) || $past(i_wait_instr))
      else $error("mode entered without wait");
   stby_wake_a:
      assert property (o_mode == 3'h7 && $rose(i_standby_wake_pin[1]) |->
         ##[1:STBY_LIM] o_mode == 3'h0) else $error("standby wake too slow");
   wdg_clk_a:
      assert property ((!i_wdg_en)[*4] |-> !o_wdg_clk_en)
      else $error("watchdog clock ignores enable");
   flash_ws_a:
      assert property (s_settled |-> o_flash_wait_state == ws_exp)
      else $error("flash wait state wrong");
endmodule
`default_nettype wire

// ===== dv/tb.sv
// testbench: mode entry, wakeup and clock checks of the sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
   import lpms_pkg::*;
   // ---
   // signals
   // ---
   logic i_clk = 0, i_rst = 1, i_irq_or_event = 0, i_sysclk_is_msi = 1;
   logic i_cal_en = 1, i_wdg_en = 1, i_tamper = 0, i_timestamp = 0;
   logic i_external_reset_pin_n = 1, i_independent_watchdog_rst = 0;
   logic i_voltage_threshold_detector = 0, i_usb_wakeup = 0;
   logic i_periodic_wakeup = 0;
   logic [1:0] i_vrange = 2'h2, i_comparator = 2'h0, i_cal_alarm = 2'h0;
   logic [2:0] i_msi_range = 3'h5, i_standby_wake_pin = 3'h0;
   logic [15:0] i_external_event_line = 16'h0000;
   wire [2:0] i_target_mode;
   wire i_wait_instr;
   wire [LPMS_KHZ_W-1:0] i_cpu_khz;
   logic [2:0] o_mode;
   logic o_cpu_clk_en, o_core_clk_en, o_pll_en, o_fast_internal_osc_en;
   logic o_fast_external_osc_en, o_multispeed_internal_osc_en, o_slow_osc_en;
   logic o_cal_clk_en, o_wdg_clk_en, o_reg_lp, o_reg_off, o_core_pwr_on;
   logic o_lp_run_ok, o_range_ok, o_flash_wait_state, o_core_reset;
   int mismatches = 0, num_checks = 0;
   lpms_top #(.STOP_WAKE_CYC(20), .STBY_WAKE_CYC(60)) uut (.*);
   lpms_cpu_model cpu (.i_clk(i_clk), .o_target(i_target_mode),
      .o_wait(i_wait_instr), .o_khz(i_cpu_khz));
   always #25 i_clk = ~i_clk;
   // ---
   // helpers
   // ---
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic chk(input string s, input logic [15:0] e, g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", s, e, g);
      end
   endtask
   task automatic await(input logic [2:0] m, input int lim);
      for (int k = 0; k < lim && o_mode !== m; k++) cyc(1);
      chk("mode", m, o_mode);
   endtask
   task automatic raise(input int i, input logic v);
      @(posedge i_clk);
      case (i)
         0: i_external_event_line <= {v, 15'h0000};
         1: i_cal_alarm <= {v, 1'b0};
         2: i_tamper <= v;
         3: i_standby_wake_pin <= {1'b0, v, 1'b0};
         4: i_external_reset_pin_n <= !v;
         5: i_independent_watchdog_rst <= v;
         7: i_timestamp <= v;
         8: i_voltage_threshold_detector <= v;
         9: i_usb_wakeup <= v;
         10: i_periodic_wakeup <= v;
         11: i_comparator <= {v, 1'b0};
         default: i_cal_alarm <= {1'b0, v};
      endcase
   endtask
   // ---
   // scenarios
   // ---
   task automatic t_sleep;
      cpu.sleep_on(3'h0);
      cyc(3);
      chk("mode", 3'h0, o_mode);
      cpu.sleep_on(3'h1);
      cyc(3);
      chk("sleep_clks", 16'h0001, {o_cpu_clk_en, o_core_clk_en});
      @(posedge i_clk) i_irq_or_event <= 1'b1;
      await(3'h0, 10);
      @(posedge i_clk) i_irq_or_event <= 1'b0;
   endtask
   task automatic t_lp;
      @(posedge i_clk) i_msi_range <= 3'h1;
      cpu.set_khz(16'h0083);
      cpu.sleep_on(3'h2);
      await(3'h2, 10);
      chk("lp_run", 16'h000b, {o_mode, o_reg_lp, o_lp_run_ok});
      cpu.sleep_on(3'h3);
      await(3'h3, 10);
      @(posedge i_clk) i_irq_or_event <= 1'b1;
      await(3'h0, 10);
      chk("reg_lp", 16'h0000, o_reg_lp);
      @(posedge i_clk) i_irq_or_event <= 1'b0;
      i_msi_range <= 3'h5;
      cpu.set_khz(16'h0fa0);
   endtask
   task automatic t_stop;
      for (int i = 0; i < 12; i++) begin
         if (i inside {[3:5]}) continue;
         @(posedge i_clk) i_cal_en <= i != 8;
         cpu.sleep_on(3'h4);
         cyc(3);
         chk("stop_clks", i == 8 ? 16'h000d : 16'h000f,
            {o_core_clk_en, o_pll_en,
            o_fast_internal_osc_en, o_fast_external_osc_en,
            o_multispeed_internal_osc_en, o_slow_osc_en, o_reg_lp,
            o_cal_clk_en, o_wdg_clk_en});
         raise(i, 1'b1);
         await(3'h0, 40);
         raise(i, 1'b0);
         cyc(4);
      end
      cpu.sleep_on(3'h5);
      @(posedge i_clk) i_wdg_en <= 1'b0;
      i_cal_alarm <= 2'h1;
      cyc(20);
      chk("stop_off", 16'h00a1, {o_mode, o_slow_osc_en,
         o_cal_clk_en, o_wdg_clk_en, o_core_clk_en, o_reg_lp});
      @(posedge i_clk) i_external_event_line <= 16'h0001;
      i_wdg_en <= 1'b1;
      await(3'h0, 40);
      @(posedge i_clk) i_external_event_line <= 16'h0000;
      i_cal_alarm <= 2'h0;
      cyc(4);
   endtask
   task automatic t_stby;
      for (int i = 3; i < 7; i++) begin
         cpu.sleep_on(i < 5 ? 3'h7 : 3'h6);
         cyc(3);
         chk("stby_pwr", 16'h0005, {o_reg_off, o_core_pwr_on,
            o_core_reset});
         raise(2, i == 3);
         cyc(20);
         chk("mode", i < 5 ? 3'h7 : 3'h6, o_mode);
         raise(i, 1'b1);
         cyc(4);
         raise(i, 1'b0);
         raise(2, 1'b0);
         await(3'h0, 90);
         chk("core_reset", 16'h0000, o_core_reset);
         cyc(4);
      end
   endtask
   task automatic t_rst;
      cpu.sleep_on(3'h4);
      cyc(3);
      @(posedge i_clk) i_rst <= 1'b1;
      cyc(2);
      chk("rst_mode", 3'h0, o_mode);
      chk("rst_ctl", 16'h3fe4, {o_cpu_clk_en, o_core_clk_en, o_pll_en,
         o_fast_internal_osc_en, o_fast_external_osc_en,
         o_multispeed_internal_osc_en, o_slow_osc_en, o_cal_clk_en,
         o_wdg_clk_en, o_reg_lp, o_reg_off, o_core_pwr_on,
         o_flash_wait_state, o_core_reset});
      @(posedge i_clk) i_rst <= 1'b0;
      cyc(2);
      chk("mode", 3'h0, o_mode);
   endtask
   task automatic t_ws;
      logic [1:0] rg[6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
      logic [15:0] kz[6] = '{16'h3e80, 16'h3e81, 16'h3e81, 16'h1f40,
         16'h0835, 16'h0834};
      logic [5:0] ms = 6'h3e, ws = 6'h1a, ok = 6'h36;
      for (int i = 0; i < 6; i++) begin
         @(posedge i_clk) i_vrange <= rg[i];
         i_sysclk_is_msi <= ms[5 - i];
         cpu.set_khz(kz[i]);
         cyc(5);
         chk("wait_state", 16'(ws[5 - i]), o_flash_wait_state);
         chk("range_ok", 16'(ok[5 - i]), o_range_ok);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge i_clk);
      i_rst <= 1'b0;
      cyc(2);
      t_sleep();
      t_lp();
      t_stop();
      t_rst();
      t_stby();
      t_ws();
      close_out();
   end
   initial begin
      #2000000;
      mismatches++;
      close_out();
   end
endmodule
bind lpms_top lpms_sva #(.STOP_WAKE_CYC(STOP_WAKE_CYC),
   .STBY_WAKE_CYC(STBY_WAKE_CYC)) chk_i (.*);
`default_nettype wire

// ===== src/lpms_pkg.sv
// package: constants and types for the low power mode sequencer
package lpms_pkg;
   // modes requested by the cpu
   typedef enum logic [2:0] {
      LPMS_RUN = 3'h0,
      LPMS_SLEEP = 3'h1,
      LPMS_LP_RUN = 3'h2,
      LPMS_LP_SLEEP = 3'h3,
      LPMS_STOP_CAL = 3'h4,
      LPMS_STOP = 3'h5,
      LPMS_STBY_CAL = 3'h6,
      LPMS_STBY = 3'h7
   } lpms_mode_e;

   // voltage ranges
   localparam logic [1:0] LPMS_RANGE1 = 2'h1;
   localparam logic [1:0] LPMS_RANGE2 = 2'h2;
   localparam logic [1:0] LPMS_RANGE3 = 2'h3;

   // frequency limits in khz
   localparam int LPMS_LP_RUN_MAX_KHZ = 131;
   localparam int LPMS_R1_MAX_KHZ = 32000;
   localparam int LPMS_R2_MAX_KHZ = 16000;
   localparam int LPMS_R3_MAX_KHZ = 4000;
   localparam int LPMS_R1_WS_KHZ = 16000;
   localparam int LPMS_R2_WS_KHZ = 8000;
   localparam int LPMS_R3_WS_KHZ = 2100;
   localparam int LPMS_KHZ_W = 16;

   // multispeed oscillator ranges allowed for low-power run
   localparam logic [2:0] LPMS_MSI_LP_MAX_RANGE = 3'h1;

   // timing
   localparam int LPMS_CLK_MHZ = 20;
   localparam int LPMS_STOP_WAKE_NS = 8000;
   localparam int LPMS_STBY_WAKE_NS = 60000;
   localparam int LPMS_STOP_WAKE_CYC = LPMS_STOP_WAKE_NS * LPMS_CLK_MHZ
      / 1000;
   localparam int LPMS_STBY_WAKE_CYC = LPMS_STBY_WAKE_NS * LPMS_CLK_MHZ
      / 1000;
   localparam int LPMS_CNT_W = 11;

   // wake source counts
   localparam int LPMS_EXT_LINES = 16;
   localparam int LPMS_WAKE_PINS = 3;

   // state after reset
   localparam logic [1:0] LPMS_RANGE_RST = 2'h2;
   // control word after reset: clocks and oscillators on, regulator normal
   localparam logic [16:0] LPMS_CTL_RST = 17'h1ff20;
endpackage

// ===== src/lpms_sync.sv
// two flip-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module lpms_sync #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // data
   lpms_sync_if.dst s
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_synced;

   initial begin
      if (W < 1) $error("lpms_sync: width must be positive");
   end

   always_comb begin
      next_meta = s.raw;
      next_synced = meta;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta <= '0;
         s.synced <= '0;
      end else begin
         meta <= next_meta;
         s.synced <= next_synced;
      end
   end
endmodule
`default_nettype wire

// ===== src/lpms_sync_if.sv
// interface: raw and synchronised wake inputs
`timescale 1ns/1ps
`default_nettype none
interface lpms_sync_if #(parameter int W = 8);
   logic [W-1:0] raw;
   logic [W-1:0] synced;
   modport src (output raw, input synced);
   modport dst (input raw, output synced);
endinterface
`default_nettype wire

// ===== src/lpms_top.sv
// low power mode sequencer: mode entry, wakeup and clock controls
// ---------------------------------------------------------------
// Notes on behaviour
// - sleep halts cpu clock, wakes on any event
// - low-power run needs msi range 0/1, lp regulator
// - low-power sleep wake returns regulator to normal
// - stop+cal gates core clocks, keeps slow osc
// - stop+cal wakes in 8us on listed lines
// - stop without cal: clocks off except watchdog, limited wake
// - standby powers off regulator and core domain
// - standby+cal exits in 60us on listed sources
// - standby exits in 60us on reset pin, wake pin
// - calendar and watchdog keep own enables
// - ranges cap cpu at 32, 16, 4 mhz
// - flash wait state above range threshold
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module lpms_top
   import lpms_pkg::*;
#(
   parameter int STOP_WAKE_CYC = LPMS_STOP_WAKE_CYC,
   parameter int STBY_WAKE_CYC = LPMS_STBY_WAKE_CYC
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // cpu side
   input wire logic [2:0] i_target_mode,
   input wire logic i_wait_instr,
   input wire logic i_irq_or_event,
   input wire logic [1:0] i_vrange,
   input wire logic [2:0] i_msi_range,
   input wire logic i_sysclk_is_msi,
   input wire logic [LPMS_KHZ_W-1:0] i_cpu_khz,
   // own enables of calendar and watchdog
   input wire logic i_cal_en,
   input wire logic i_wdg_en,
   // wake sources (from outside the clock domain)
   input wire logic [LPMS_EXT_LINES-1:0] i_external_event_line,
   input wire logic i_voltage_threshold_detector,
   input wire logic [1:0] i_comparator,
   input wire logic i_usb_wakeup,
   input wire logic [1:0] i_cal_alarm,
   input wire logic i_tamper,
   input wire logic i_timestamp,
   input wire logic i_periodic_wakeup,
   input wire logic i_external_reset_pin_n,
   input wire logic i_independent_watchdog_rst,
   input wire logic [LPMS_WAKE_PINS-1:0] i_standby_wake_pin,
   // clock and power controls
   output logic [2:0] o_mode,
   output logic o_cpu_clk_en,
   output logic o_core_clk_en,
   output logic o_pll_en,
   output logic o_fast_internal_osc_en,
   output logic o_fast_external_osc_en,
   output logic o_multispeed_internal_osc_en,
   output logic o_slow_osc_en,
   output logic o_cal_clk_en,
   output logic o_wdg_clk_en,
   output logic o_reg_lp,
   output logic o_reg_off,
   output logic o_core_pwr_on,
   output logic o_lp_run_ok,
   output logic o_range_ok,
   output logic o_flash_wait_state,
   output logic o_core_reset
);
   localparam int NW = LPMS_EXT_LINES + 15;

   typedef enum logic [2:0] {
      ST_RUN = 3'h0,
      ST_LOW = 3'h1,
      ST_WAKE = 3'h2
   } lpms_state_e;

   initial begin
      if (STOP_WAKE_CYC < 1 || STOP_WAKE_CYC >= (1 << LPMS_CNT_W))
         $error("lpms_top: stop wake count out of range");
      if (STBY_WAKE_CYC < 1 || STBY_WAKE_CYC >= (1 << LPMS_CNT_W))
         $error("lpms_top: standby wake count out of range");
   end

   // ------------------------------------------------------------
   // synchronise pin inputs
   // ------------------------------------------------------------
   lpms_sync_if #(.W(NW)) sif ();
   assign sif.raw = {i_external_event_line, i_voltage_threshold_detector,
      i_comparator, i_usb_wakeup, i_cal_alarm, i_tamper, i_timestamp,
      i_periodic_wakeup, ~i_external_reset_pin_n,
      i_independent_watchdog_rst, i_standby_wake_pin, i_irq_or_event};

   lpms_sync #(.W(NW)) u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .s(sif.dst)
   );

   logic [LPMS_EXT_LINES-1:0] s_ext;
   logic s_pvd, s_usb, s_tamp, s_ts, s_per, s_rst_pin, s_wdg, s_irq;
   logic [1:0] s_cmp, s_alarm;
   logic [LPMS_WAKE_PINS-1:0] s_pin, pin_prev, next_pin_prev;
   assign {s_ext, s_pvd, s_cmp, s_usb, s_alarm, s_tamp, s_ts, s_per,
      s_rst_pin, s_wdg, s_pin, s_irq} = sif.synced;

   // ------------------------------------------------------------
   // wake decode per mode
   // ------------------------------------------------------------
   logic stop_cal_wake, stop_wake, stby_cal_wake, stby_wake, pin_rise;
   always_comb begin
      pin_rise = |(s_pin & ~pin_prev);
      stop_wake = |s_ext | s_pvd | |s_cmp | s_usb;
      stop_cal_wake = stop_wake | |s_alarm | s_tamp | s_ts | s_per;
      stby_wake = s_rst_pin | pin_rise;
      stby_cal_wake = stby_wake | s_wdg | |s_alarm | s_tamp | s_ts
         | s_per;
   end

   // ------------------------------------------------------------
   // mode sequencer
   // ------------------------------------------------------------
   lpms_state_e state, next_state;
   lpms_mode_e mode, next_mode, lp_mode, next_lp_mode;
   logic [LPMS_CNT_W-1:0] cnt, next_cnt;
   logic lp_run_ok, next_lp_run_ok;

   always_comb begin
      next_lp_run_ok = i_sysclk_is_msi
         && i_msi_range <= LPMS_MSI_LP_MAX_RANGE
         && i_cpu_khz <= LPMS_KHZ_W'(LPMS_LP_RUN_MAX_KHZ);
   end

   always_comb begin
      next_state = state;
      next_mode = mode;
      next_lp_mode = lp_mode;
      next_cnt = cnt;
      next_pin_prev = s_pin;
      unique case (state)
         ST_RUN: begin
            if (i_target_mode == LPMS_LP_RUN && lp_run_ok)
               next_mode = LPMS_LP_RUN;
            else if (i_target_mode == LPMS_RUN || !lp_run_ok)
               next_mode = LPMS_RUN;
            if (i_wait_instr && i_target_mode != LPMS_RUN
                  && i_target_mode != LPMS_LP_RUN) begin
               next_lp_mode = lpms_mode_e'(i_target_mode);
               if (i_target_mode == LPMS_LP_SLEEP && !lp_run_ok)
                  next_lp_mode = LPMS_SLEEP;
               next_mode = next_lp_mode;
               next_state = ST_LOW;
            end
         end
         ST_LOW: begin
            unique case (lp_mode)
               LPMS_SLEEP, LPMS_LP_SLEEP: begin
                  if (s_irq) begin
                     next_mode = LPMS_RUN;
                     next_state = ST_RUN;
                  end
               end
               LPMS_STOP_CAL, LPMS_STOP: begin
                  if (lp_mode == LPMS_STOP_CAL ? stop_cal_wake
                        : stop_wake) begin
                     next_cnt = LPMS_CNT_W'(STOP_WAKE_CYC);
                     next_state = ST_WAKE;
                  end
               end
               default: begin
                  if (lp_mode == LPMS_STBY_CAL ? stby_cal_wake
                        : stby_wake) begin
                     next_cnt = LPMS_CNT_W'(STBY_WAKE_CYC);
                     next_state = ST_WAKE;
                  end
               end
            endcase
         end
         ST_WAKE: begin
            next_cnt = cnt - 1'b1;
            if (cnt <= LPMS_CNT_W'(1)) begin
               next_mode = LPMS_RUN;
               next_state = ST_RUN;
            end
         end
         default: next_state = ST_RUN;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state <= ST_RUN;
         mode <= LPMS_RUN;
         lp_mode <= LPMS_SLEEP;
         cnt <= '0;
         lp_run_ok <= 1'b0;
         pin_prev <= '0;
      end else begin
         state <= next_state;
         mode <= next_mode;
         lp_mode <= next_lp_mode;
         cnt <= next_cnt;
         lp_run_ok <= next_lp_run_ok;
         pin_prev <= next_pin_prev;
      end
   end

   // ------------------------------------------------------------
   // clock, oscillator and regulator controls
   // ------------------------------------------------------------
   logic [16:0] next_ctl;
   logic stop_any, stby_any, slow_keep, lp_reg, rng_ok, fws;
   always_comb begin
      stop_any = mode == LPMS_STOP_CAL || mode == LPMS_STOP;
      stby_any = mode == LPMS_STBY_CAL || mode == LPMS_STBY;
      slow_keep = mode != LPMS_STOP;
      lp_reg = mode == LPMS_LP_RUN || mode == LPMS_LP_SLEEP || stop_any;
      unique case (i_vrange)
         LPMS_RANGE1: rng_ok = i_cpu_khz <= LPMS_KHZ_W'(LPMS_R1_MAX_KHZ);
         LPMS_RANGE2: rng_ok = i_cpu_khz <= LPMS_KHZ_W'(LPMS_R2_MAX_KHZ);
         LPMS_RANGE3: rng_ok = i_sysclk_is_msi
            && i_cpu_khz <= LPMS_KHZ_W'(LPMS_R3_MAX_KHZ);
         default: rng_ok = 1'b0;
      endcase
      unique case (i_vrange)
         LPMS_RANGE1: fws = i_cpu_khz > LPMS_KHZ_W'(LPMS_R1_WS_KHZ);
         LPMS_RANGE2: fws = i_cpu_khz > LPMS_KHZ_W'(LPMS_R2_WS_KHZ);
         LPMS_RANGE3: fws = i_cpu_khz > LPMS_KHZ_W'(LPMS_R3_WS_KHZ);
         default: fws = 1'b1;
      endcase
      next_ctl = {
         mode == LPMS_RUN || mode == LPMS_LP_RUN,
         !(stop_any || stby_any),
         !(stop_any || stby_any) && mode != LPMS_LP_RUN
            && mode != LPMS_LP_SLEEP,
         !(stop_any || stby_any),
         !(stop_any || stby_any) && mode != LPMS_LP_RUN
            && mode != LPMS_LP_SLEEP,
         !(stop_any || stby_any),
         slow_keep,
         i_cal_en && slow_keep,
         i_wdg_en,
         lp_reg,
         stby_any,
         !stby_any,
         lp_run_ok,
         rng_ok,
         fws,
         stby_any || (state == ST_WAKE && (lp_mode == LPMS_STBY
            || lp_mode == LPMS_STBY_CAL)),
         1'b0
      };
   end

   logic [16:0] ctl;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctl <= LPMS_CTL_RST;
         o_mode <= 3'h0;
      end else begin
         ctl <= next_ctl;
         o_mode <= mode;
      end
   end

   assign {o_cpu_clk_en, o_core_clk_en, o_pll_en, o_fast_internal_osc_en,
      o_fast_external_osc_en, o_multispeed_internal_osc_en, o_slow_osc_en,
      o_cal_clk_en, o_wdg_clk_en, o_reg_lp, o_reg_off, o_core_pwr_on,
      o_lp_run_ok, o_range_ok, o_flash_wait_state, o_core_reset} =
      ctl[16:1];
endmodule
`default_nettype wire
